// ==== core/cih_pkg.sv ====
// Function
// (R1) External reset held at least 1 ms after supply and clock are valid.
// (R2) Reset input is active high, asynchronous; forces a defined start state.
// (R3) Maskable interrupt taken only while the flags word enable bit is set.
// (R4) Accepted maskable interrupt runs two locked acknowledges back to back.
// (R5) Source keeps maskable request high until both acknowledges are done.
// (R6) Non-maskable interrupt is rising-edge detected, one request per edge.
// (R7) Source holds non-maskable input low four clocks before its rising edge.
// (R8) Cycle-pending output high while an internal bus request is pending.
// (R9) Cycle-pending output is always driven, also during bus hold.
// (R10) Hold request makes the device float its bus pins.
// (R11) Hold granted only after current cycle, burst or locked sequence ends.
// (R12) Device stays off the bus until hold request drops.
// (R13) Hold acknowledge rises in the same clock the bus floats.
// (R14) Hold acknowledge falls when the device takes the bus back.
// (R15) Hold acknowledge stays driven through the whole hold period.
// (R16) Reset, interrupt and hold inputs pass a multi-stage synchroniser.
// (R17) Pending non-maskable request is serviced before a maskable one.
`default_nettype none

package cih_pkg;

  // Interrupt enable bit inside the processor flags word
  localparam int unsigned CIH_IF_BIT = 9;
  // Synchroniser depth and the lanes of the synchronised vector
  localparam int unsigned CIH_SYNC_STAGES = 3;
  localparam int unsigned CIH_SYNC_W = 4;
  localparam int unsigned CIH_SI_RESET = 0;
  localparam int unsigned CIH_SI_MASKABLE_IRQ_IN = 1;
  localparam int unsigned CIH_SI_NMI = 2;
  localparam int unsigned CIH_SI_HOLD = 3;
  // Least low time of the non-maskable input before an edge, in clocks
  localparam logic [2:0] CIH_NMI_LOW_MIN = 3'h4;
  // Burst beat counter width; at most four beats by default
  localparam int unsigned CIH_BEAT_W = 2;
  localparam int unsigned CIH_VEC_W = 8;

  typedef enum logic [2:0] {
    CIH_ST_IDLE,
    CIH_ST_CYC,
    CIH_ST_INTA1,
    CIH_ST_INTA2,
    CIH_ST_HOLD
  } cih_state_t;

endpackage

`default_nettype wire

// ==== core/cih_sync.sv ====
`default_nettype none

// Multi-flop synchroniser for a vector of independent levels
module cih_sync #(
  parameter int unsigned WIDTH  = 4,
  parameter int unsigned STAGES = 3
) (
  input  wire  logic             clk_sys,
  input  wire  logic             rstn,
  input  wire  logic [WIDTH-1:0] async_in,
  output var   logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_ff [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("cih_sync needs at least two stages");
  end

  // First stage feeds only the second; no logic taps it
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_ff[i] <= '0;
    end
    else
    begin
      stage_ff[0] <= async_in;
      for (int i = 1; i < STAGES; i++)
        stage_ff[i] <= stage_ff[i-1];
    end
  end

  assign sync_out = stage_ff[STAGES-1];

endmodule

`default_nettype wire

// ==== core/cih_top.sv ====
`default_nettype none

// Reset entry, interrupt intake and bus hold arbitration for the core
module cih_top #(
  parameter int unsigned BEAT_W = cih_pkg::CIH_BEAT_W,
  parameter int unsigned VEC_W  = cih_pkg::CIH_VEC_W
) (
  input  wire  logic              clk_sys,
  input  wire  logic              rstn,
  input  wire  logic              reset_in,
  input  wire  logic              maskable_irq_in,
  input  wire  logic              nmi_in,
  input  wire  logic              hold_req_in,
  input  wire  logic [31:0]       processor_flags_word,
  input  wire  logic              core_req_in,
  input  wire  logic [BEAT_W-1:0] core_beats_in,
  input  wire  logic              core_lock_in,
  input  wire  logic              bus_rdy_in,
  input  wire  logic [VEC_W-1:0]  inta_data_in,
  output var   logic              core_reset_out,
  output var   logic              internal_cycle_pending_out,
  output var   logic              bus_grant_ack_out,
  output var   logic              bus_drive_en_out,
  output var   logic              bus_cycle_out,
  output var   logic              inta_cycle_out,
  output var   logic              nmi_take_out,
  output var   logic              maskable_irq_in_take_out,
  output var   logic [VEC_W-1:0]  maskable_irq_in_vector_out
);

  import cih_pkg::*;

  if (BEAT_W < 1 || VEC_W < 1) begin : g_bad_width
    $error("cih_top widths must be at least one");
  end

  logic [CIH_SYNC_W-1:0] sync_vec;
  logic                  reset_s;
  logic                  maskable_irq_in_s;
  logic                  nmi_s;
  logic                  hold_s;
  logic                  rst_all;
  cih_state_t            state_ff;
  cih_state_t            nxt_state;
  logic [BEAT_W-1:0]     beat_cnt_ff;
  logic [BEAT_W-1:0]     beat_len_ff;
  logic                  nmi_prev_ff;
  logic [2:0]            nmi_low_ff;
  logic                  nmi_pend_ff;
  logic                  nmi_edge;
  logic                  go_hold;
  logic                  nmi_serv;
  logic                  maskable_irq_in_ok;
  logic                  cyc_last;

  // Pins are asynchronous; all four cross through one synchroniser
  cih_sync #(
    .WIDTH  (CIH_SYNC_W),
    .STAGES (CIH_SYNC_STAGES)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({hold_req_in, nmi_in, maskable_irq_in, !reset_in}),
    .sync_out (sync_vec)
  ); // R16

  assign reset_s = !sync_vec[CIH_SI_RESET]; // Cleared lane reads as reset
  assign maskable_irq_in_s  = sync_vec[CIH_SI_MASKABLE_IRQ_IN];
  assign nmi_s   = sync_vec[CIH_SI_NMI];
  assign hold_s  = sync_vec[CIH_SI_HOLD];
  assign rst_all = !rstn || reset_s; // R2

  // Arbitration terms; a held lock keeps the bus even between cycles
  assign go_hold  = hold_s && !core_lock_in; // R11
  assign nmi_serv = (state_ff == CIH_ST_IDLE) && !go_hold && nmi_pend_ff;
  assign maskable_irq_in_ok  = maskable_irq_in_s && processor_flags_word[CIH_IF_BIT]
                    && !nmi_pend_ff; // R3 R17
  assign cyc_last = bus_rdy_in && (beat_cnt_ff == beat_len_ff);

  // Bus state transitions
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      CIH_ST_IDLE:
      begin
        if (go_hold)
          nxt_state = CIH_ST_HOLD; // R10
        else if (nmi_pend_ff)
          nxt_state = CIH_ST_IDLE; // R17
        else if (maskable_irq_in_ok)
          nxt_state = CIH_ST_INTA1; // R4
        else if (core_req_in)
          nxt_state = CIH_ST_CYC;
      end
      CIH_ST_CYC:
      begin
        if (cyc_last)
          nxt_state = CIH_ST_IDLE; // R11
      end
      CIH_ST_INTA1:
      begin
        if (bus_rdy_in)
          nxt_state = CIH_ST_INTA2; // R4
      end
      CIH_ST_INTA2:
      begin
        if (bus_rdy_in)
          nxt_state = CIH_ST_IDLE;
      end
      CIH_ST_HOLD:
      begin
        if (!hold_s)
          nxt_state = CIH_ST_IDLE; // R12
      end
    endcase
  end

  // State register and pin-facing flags move together, so the grant
  // and the float of the bus land on the same edge
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      state_ff          <= CIH_ST_IDLE;
      bus_grant_ack_out <= 1'b0;
      bus_drive_en_out  <= 1'b1;
      bus_cycle_out     <= 1'b0;
      inta_cycle_out    <= 1'b0;
    end
    else
    begin
      state_ff          <= nxt_state;
      bus_grant_ack_out <= (nxt_state == CIH_ST_HOLD); // R13 R14 R15
      bus_drive_en_out  <= (nxt_state != CIH_ST_HOLD); // R10 R12
      bus_cycle_out     <= (nxt_state == CIH_ST_CYC);
      inta_cycle_out    <= (nxt_state == CIH_ST_INTA1)
                           || (nxt_state == CIH_ST_INTA2);
    end
  end

  // Burst beat counting; length latched at cycle start
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      beat_cnt_ff <= '0;
      beat_len_ff <= '0;
    end
    else if (state_ff == CIH_ST_IDLE)
    begin
      beat_cnt_ff <= '0;
      beat_len_ff <= core_beats_in;
    end
    else if (state_ff == CIH_ST_CYC && bus_rdy_in)
      beat_cnt_ff <= beat_cnt_ff + 1'b1;
  end

  // Low-time qualified edge detector on the synchronised input
  assign nmi_edge = nmi_s && !nmi_prev_ff && (nmi_low_ff >= CIH_NMI_LOW_MIN);

  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      nmi_prev_ff <= 1'b0;
      nmi_low_ff  <= 3'h0;
    end
    else
    begin
      nmi_prev_ff <= nmi_s;
      if (nmi_s)
        nmi_low_ff <= 3'h0;
      else if (nmi_low_ff < CIH_NMI_LOW_MIN)
        nmi_low_ff <= nmi_low_ff + 3'h1; // R7
    end
  end

  // Pending flag; a new edge wins over the clear of the previous one
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
      nmi_pend_ff <= 1'b0;
    else if (nmi_edge)
      nmi_pend_ff <= 1'b1; // R6
    else if (nmi_serv)
      nmi_pend_ff <= 1'b0;
  end

  // Service strobes and vector capture from the second acknowledge
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      nmi_take_out    <= 1'b0;
      maskable_irq_in_take_out   <= 1'b0;
      maskable_irq_in_vector_out <= '0;
    end
    else
    begin
      nmi_take_out  <= nmi_serv; // R17
      maskable_irq_in_take_out <= (state_ff == CIH_ST_INTA2) && bus_rdy_in;
      if (state_ff == CIH_ST_INTA2 && bus_rdy_in)
        maskable_irq_in_vector_out <= inta_data_in;
    end
  end

  // Pending output never floats; it also counts an acknowledge owed
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      core_reset_out             <= 1'b1;
      internal_cycle_pending_out <= 1'b0;
    end
    else
    begin
      core_reset_out             <= 1'b0;
      internal_cycle_pending_out <= core_req_in || maskable_irq_in_ok; // R8 R9
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst_all);

  sequence s_inta_pair;
    (state_ff == CIH_ST_INTA1) && bus_rdy_in
    ##1 (state_ff == CIH_ST_INTA2) && inta_cycle_out;
  endsequence

  sequence s_hold_enter;
    (state_ff == CIH_ST_IDLE) && go_hold;
  endsequence

  AST_INTA_LOCKED: assert property ( // R4
    $rose(state_ff == CIH_ST_INTA1) |-> !bus_grant_ack_out
      throughout ((state_ff == CIH_ST_INTA1 || state_ff == CIH_ST_INTA2)
      [*2])
  ) else $error("grant during acknowledge pair");

  AST_INTA_NEXT: assert property ( // R4
    (state_ff == CIH_ST_INTA1) && bus_rdy_in |-> s_inta_pair
  ) else $error("second acknowledge not started");

  AST_INTA_TAKE: assert property ( // R4
    (state_ff == CIH_ST_INTA2) && bus_rdy_in |=>
      maskable_irq_in_take_out && !inta_cycle_out
  ) else $error("second acknowledge did not finish the pair");

  AST_IF_MASK: assert property ( // R3
    (state_ff == CIH_ST_IDLE) && !processor_flags_word[CIH_IF_BIT] |=>
      state_ff != CIH_ST_INTA1
  ) else $error("acknowledge started with interrupts masked");

  AST_NMI_EDGE: assert property ( // R6
    nmi_edge |=> nmi_pend_ff
  ) else $error("edge did not set pending request");

  AST_NMI_FIRST: assert property ( // R17
    (state_ff == CIH_ST_IDLE) && nmi_pend_ff && !go_hold |=>
      nmi_take_out && state_ff == CIH_ST_IDLE
  ) else $error("maskable request overtook non-maskable");

  AST_HOLD_FLOAT: assert property ( // R10 R13
    s_hold_enter |=> bus_grant_ack_out && !bus_drive_en_out
  ) else $error("grant and float not in the same clock");

  AST_NO_MIDCYCLE: assert property ( // R11
    (state_ff == CIH_ST_CYC) && !cyc_last |=> !bus_grant_ack_out
  ) else $error("grant inside a bus cycle");

  AST_LOCK_HELD: assert property ( // R11
    core_lock_in && !bus_grant_ack_out |=> !bus_grant_ack_out
  ) else $error("grant during locked sequence");

  AST_HOLD_STAY: assert property ( // R12 R15
    bus_grant_ack_out && hold_s |=> bus_grant_ack_out && !bus_drive_en_out
  ) else $error("hold left while still requested");

  AST_HOLD_EXIT: assert property ( // R14
    bus_grant_ack_out && !hold_s |=> !bus_grant_ack_out ##0 bus_drive_en_out
  ) else $error("grant not dropped on hold release");

  AST_PENDING: assert property ( // R8
    core_req_in |=> internal_cycle_pending_out
  ) else $error("pending output missed a request");

endmodule

`default_nettype wire

// ==== verification/cih_far_model.sv ====
`default_nettype none

// Interrupt source, other bus master and ready/vector responder
module cih_far_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       irq_go,
  input  wire logic       nmi_go,
  input  wire logic       hold_lvl,
  input  wire logic [7:0] vec,
  input  wire logic [1:0] gap,
  input  wire logic       bus_cycle_out,
  input  wire logic       inta_cycle_out,
  input  wire logic       maskable_irq_in_take_out,
  output var  logic       maskable_irq_in,
  output var  logic       nmi_in,
  output var  logic       hold_req_in,
  output var  logic       bus_rdy_in,
  output var  logic [7:0] inta_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ph_cnt;
  logic       nmi_owed;
  logic [1:0] wait_cnt;

  // Level request kept up until the acknowledge pair is over
  always @(negedge clk_sys)
  begin
    if (!rstn || maskable_irq_in_take_out)
      maskable_irq_in <= 1'h0;
    else if (irq_go)
      maskable_irq_in <= 1'h1;
    hold_req_in <= rstn && hold_lvl;
  end

  // Edge only after a low phase longer than the minimum
  always @(negedge clk_sys)
  begin
    if (nmi_go)
      nmi_owed <= 1'h1;
    if (!rstn)
    begin
      nmi_in   <= 1'h0;
      ph_cnt   <= 4'h0;
      nmi_owed <= 1'h0;
    end
    else if (nmi_in ? ph_cnt == 4'h4 : nmi_owed && ph_cnt >= 4'h5)
    begin
      nmi_in   <= !nmi_in;
      ph_cnt   <= 4'h0;
      nmi_owed <= nmi_in && nmi_owed;
    end
    else if (ph_cnt != 4'hf)
      ph_cnt <= ph_cnt + 4'h1;
  end

  // Ready after gap waits; gap of one or more keeps it off the first clock
  always @(negedge clk_sys)
  begin
    if (!rstn || bus_rdy_in || !(bus_cycle_out || inta_cycle_out))
    begin
      bus_rdy_in <= 1'h0;
      wait_cnt   <= 2'h0;
    end
    else if (wait_cnt >= gap)
      bus_rdy_in <= 1'h1;
    else
      wait_cnt <= wait_cnt + 2'h1;
    // Released vector lines toggle so stale data never matches
    inta_data_in <= !rstn ? 8'h00 : inta_cycle_out ? vec : ~inta_data_in;
  end
endmodule

`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none

// Random core cycles, hold arbitration and interrupt intake
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cih_pkg::*;
  localparam int GNT = 0, CYC = 1, ACK = 2, NMI = 3, TAKE = 4;
  // Power-up reset pin hold: 1 ms of 20 ns clocks
  localparam int RST_HOLD_CYC = 50000;
  logic        clk_sys = 1'h0, rstn = 1'h0, reset_in = 1'h1;
  logic [31:0] processor_flags_word = '0;
  logic        core_req_in = 1'h0, core_lock_in = 1'h0, bus_rdy_in;
  logic [1:0]  core_beats_in = 2'h0, gap = 2'h1;
  logic        irq_go = 1'h0, nmi_go = 1'h0, hold_lvl = 1'h0;
  logic [7:0]  vec = 8'h00, inta_data_in, maskable_irq_in_vector_out;
  logic        maskable_irq_in, nmi_in, hold_req_in, core_reset_out;
  logic        internal_cycle_pending_out, bus_grant_ack_out;
  logic        bus_drive_en_out, bus_cycle_out, inta_cycle_out;
  logic        nmi_take_out, maskable_irq_in_take_out;
  int          bad_count = 0, num_checks = 0, beats, acks, nmi_seen, seed;

  cih_top i_cih_top (.clk_sys, .rstn, .reset_in, .maskable_irq_in, .nmi_in,
    .hold_req_in, .processor_flags_word, .core_req_in, .core_beats_in,
    .core_lock_in, .bus_rdy_in, .inta_data_in, .core_reset_out,
    .internal_cycle_pending_out, .bus_grant_ack_out, .bus_drive_en_out,
    .bus_cycle_out, .inta_cycle_out, .nmi_take_out, .maskable_irq_in_take_out,
    .maskable_irq_in_vector_out);
  cih_far_model i_cih_far_model (.clk_sys, .rstn, .irq_go, .nmi_go,
    .hold_lvl, .vec, .gap, .bus_cycle_out, .inta_cycle_out, .maskable_irq_in_take_out,
    .maskable_irq_in, .nmi_in, .hold_req_in, .bus_rdy_in, .inta_data_in);

  always #10 clk_sys = ~clk_sys;

  task automatic chk(input string n, input logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait on one output reaching a level
  task automatic wait_on(input int sel, input logic v);
    logic [4:0] w;
    for (int i = 0; i < 40; i++)
    begin
      w = {maskable_irq_in_take_out, nmi_take_out, inta_cycle_out, bus_cycle_out,
           bus_grant_ack_out};
      if (w[sel] === v)
        return;
      cyc(1);
    end
  endtask
  task automatic core_cycle(input logic [1:0] b);
    core_beats_in <= b;
    core_req_in <= 1'h1;
    beats = 0;
    cyc(1);
    chk("pending", 1, internal_cycle_pending_out);
    wait_on(CYC, 1'h1);
    core_req_in <= 1'h0;
    wait_on(CYC, 1'h0);
    chk("beats", b + 32'h1, beats);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ready beats and acknowledges, counted on the sampling edge
  always @(posedge clk_sys)
  begin
    if (bus_rdy_in && bus_cycle_out)
      beats++;
    if (bus_rdy_in && inta_cycle_out)
      acks++;
  end
  // Grant matches floating off and is exclusive with any own cycle
  always @(negedge clk_sys)
  begin
    if (rstn)
    begin
      chk("grant vs drive", !bus_drive_en_out, bus_grant_ack_out);
      if (bus_grant_ack_out)
        chk("cycle in hold", 0, bus_cycle_out | inta_cycle_out);
    end
    if (nmi_take_out)
      nmi_seen++;
  end

  initial
  begin
    #1500us;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    seed = $urandom(84440);
    cyc(2);
    rstn <= 1'h1;
    cyc(RST_HOLD_CYC);
    chk("reset held", 1, core_reset_out);
    reset_in <= 1'h0;
    cyc(8);
    chk("reset left", 0, core_reset_out);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      gap <= 2'h1 + 2'($urandom % 3);
      core_cycle(2'($urandom));
    end
    $display("test cycles done");
    hold_lvl <= 1'h1;
    cyc(3);
    chk("sync delay", 0, bus_grant_ack_out);
    wait_on(GNT, 1'h1);
    chk("grant", 1, bus_grant_ack_out);
    core_lock_in <= 1'h1;
    hold_lvl <= 1'h0;
    wait_on(GNT, 1'h0);
    chk("grant off", 0, bus_grant_ack_out);
    hold_lvl <= 1'h1;
    cyc(10);
    chk("lock blocks", 0, bus_grant_ack_out);
    core_lock_in <= 1'h0;
    cyc(3);
    chk("after lock", 1, bus_grant_ack_out);
    hold_lvl <= 1'h0;
    wait_on(GNT, 1'h0);
    $display("test hold done");
    gap <= 2'h3;
    fork
      core_cycle(2'h3);
      begin
        cyc(3);
        hold_lvl <= 1'h1;
      end
    join
    wait_on(GNT, 1'h1);
    core_req_in <= 1'h1;
    cyc(6);
    chk("pend in hold", 1, internal_cycle_pending_out);
    chk("off bus", 0, bus_cycle_out);
    chk("grant held", 1, bus_grant_ack_out);
    hold_lvl <= 1'h0;
    wait_on(GNT, 1'h0);
    chk("grant drop", 0, bus_grant_ack_out);
    core_cycle(core_beats_in);
    $display("test burst hold done");
    vec <= 8'($urandom);
    processor_flags_word <= 32'($urandom) & ~(32'h1 << CIH_IF_BIT);
    irq_go <= 1'h1;
    cyc(1);
    irq_go <= 1'h0;
    cyc(10);
    chk("masked ack", 0, inta_cycle_out);
    chk("masked pend", 0, internal_cycle_pending_out);
    processor_flags_word <= 32'($urandom) | (32'h1 << CIH_IF_BIT);
    acks = 0;
    wait_on(ACK, 1'h1);
    chk("ack start", 1, inta_cycle_out);
    hold_lvl <= 1'h1;
    wait_on(TAKE, 1'h1);
    chk("ack count", 2, acks);
    chk("vector", vec, maskable_irq_in_vector_out);
    wait_on(GNT, 1'h1);
    chk("grant after", 1, bus_grant_ack_out);
    $display("test maskable done");
    vec <= 8'($urandom);
    nmi_seen = 0;
    acks = 0;
    irq_go <= 1'h1;
    nmi_go <= 1'h1;
    cyc(1);
    irq_go <= 1'h0;
    nmi_go <= 1'h0;
    cyc(12);
    hold_lvl <= 1'h0;
    wait_on(NMI, 1'h1);
    chk("nmi first", 0, acks | inta_cycle_out);
    wait_on(TAKE, 1'h1);
    processor_flags_word <= '0;
    chk("vector 2", vec, maskable_irq_in_vector_out);
    chk("one per edge", 1, nmi_seen);
    nmi_go <= 1'h1;
    cyc(1);
    nmi_go <= 1'h0;
    cyc(20);
    chk("second edge", 2, nmi_seen);
    $display("test nmi done");
    reset_in <= 1'h1;
    cyc(5);
    chk("core reset", 1, core_reset_out);
    reset_in <= 1'h0;
    cyc(8);
    chk("reset over", 0, core_reset_out);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
